// ### core/srb_pkg.sv
// Shared constants for the serial reset and busy sequencer, both ends.
// Assumes a single 25 MHz system clock on each end.
package srb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int DEGLITCH_NS = 3000;
  // Self-timed interval, longest time so rounded down.
  localparam int DEGLITCH_CYC = DEGLITCH_NS / CLK_NS;
  localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
  localparam logic [3:0] RST_HOLD_TICKS = 4'h8;

  // ==========================================================================
  // Serial word layout
  localparam int WORD_BITS = 26;
  localparam int RW_BIT = 25;
  localparam int ADDR_HI = 24;
  localparam int ADDR_LO = 18;
  localparam int CH_HI = 17;
  localparam int CH_LO = 16;
  localparam int DATA_HI = 15;
  localparam logic [4:0] WORD_BITS_C = 5'h1A;

  typedef logic [6:0] srb_addr_t;
  typedef logic [WORD_BITS-1:0] srb_word_t;

  localparam srb_addr_t ADDR_NOP0 = 7'h00;
  localparam srb_addr_t ADDR_NOP1 = 7'h20;
  localparam srb_addr_t ADDR_NOP2 = 7'h50;
  localparam srb_addr_t ADDR_NOP3 = 7'h60;
  localparam srb_addr_t ADDR_DAC_LAST = 7'h0F;
  localparam srb_addr_t ADDR_DRV_LOW = 7'h01;
  localparam srb_addr_t ADDR_DRV_HIGH = 7'h03;
  localparam srb_addr_t ADDR_SOFT_RST = 7'h7E;
  localparam int SOFT_RST_BIT = 0;

  // ==========================================================================
  // Busy lengths and rearm wait in rising serial-clock edges
  localparam logic [9:0] RESET_CLKS = 10'h2E8;
  localparam logic [9:0] CLKS_NOP = 10'h003;
  localparam logic [9:0] CLKS_DAC = 10'h012;
  localparam logic [9:0] CLKS_DRV = 10'h015;
  localparam logic [9:0] REARM_CLKS = 10'h004;

  // ==========================================================================
  // Static reset state values
  localparam logic [7:0] LOAD_CURRENT_UA = 8'h64;
  localparam logic [7:0] THERM_LIMIT_C = 8'h64;

  // ==========================================================================
  // Host register offsets on the AHB-Lite slave
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Edges that an instruction needs after select release.
  function automatic logic [9:0] srb_busy_need(input srb_word_t w);
    srb_addr_t a;
    a = w[ADDR_HI:ADDR_LO];
    if (w[RW_BIT])
      srb_busy_need = CLKS_NOP;
    else if (a == ADDR_SOFT_RST && w[SOFT_RST_BIT])
      srb_busy_need = RESET_CLKS;
    else if (a == ADDR_DRV_LOW || a == ADDR_DRV_HIGH)
      srb_busy_need = CLKS_DRV;
    else if (a == ADDR_NOP0 || a == ADDR_NOP1 || a == ADDR_NOP2 ||
             a == ADDR_NOP3)
      srb_busy_need = CLKS_NOP;
    else if (a <= ADDR_DAC_LAST)
      srb_busy_need = CLKS_DAC;
    else
      srb_busy_need = CLKS_NOP;
  endfunction

endpackage

// ### core/srb_link_if.sv
// Serial link between the supervisory host and the sequenced device.
// Busy is open drain with a pull-up; the wire level is resolved here.
`timescale 1ns/1ps
interface srb_link_if;
  logic rst_n;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic busy_o;
  logic busy_oe;
  logic busy_n;

  // ==========================================================================
  // Pull-up resolution of the open-drain busy line.
  assign busy_n = busy_oe ? busy_o : 1'b1;

  modport dev (input rst_n, cs_n, sclk, sdi, output busy_o, busy_oe);
  modport host (output rst_n, cs_n, sclk, sdi, input busy_n);
endinterface

// ### core/srb_dev_end.sv
// Device end: reset sequencing, instruction capture and busy counting.
// Assumes link pins arrive asynchronous to hclk and are resynchronised.
`timescale 1ns/1ps

// Overview of operation
// - Hardware reset pin acts asynchronously.
// - Host holds reset low through power-up.
// - Soft reset starts on first edge after select.
// - Reset asserts busy, defaults control and calibration.
// - Reset grounds levels, disables driver and measurement.
// - Reset enables 100 uA loads, ground commutation.
// - Static state until first or second edge.
// - Clocked phase takes 744 edges, busy throughout.
// - Clocked phase initialises controller, DACs, thermal alarm.
// - After 744 edges release busy, start deglitch.
// - Every valid instruction asserts busy.
// - Host may reselect after rearm edge count.
// - Host waits out busy after reset.
// - Host clocks while busy is asserted.
// - Host may stop clock after busy ends.
// - Busy length fixed by instruction type.
// - No-operation writes need 3 edges.
// - Non-converter writes from 0x10 up, other than soft reset, need 3.
// - Other level converter writes need 18.
// - Drive-low and drive-high writes need 21.
// - Word holds address, channel, direction, data.
module srb_dev_end
  import srb_pkg::*;
(
  input wire logic hclk,              // System clock.
  input wire logic hresetn,           // Async reset, active low.
  srb_link_if.dev lnk,                // Serial link to the host.
  output logic instr_valid,           // One-cycle pulse per instruction.
  output logic instr_read,            // Instruction was a read.
  output logic [6:0] instr_addr,      // Register address.
  output logic [1:0] instr_chan,      // Channel selection.
  output logic [15:0] instr_data,     // Write data.
  output logic reset_hold,            // Static reset state active.
  output logic ctrl_default,          // Control registers at default.
  output logic cal_clear,             // Calibration registers cleared.
  output logic level_to_ground,       // Levels forced to ground ref.
  output logic driver_off,            // Driver disabled.
  output logic pmu_off,               // Parametric unit disabled.
  output logic load_force_on,         // Active loads forced on.
  output logic [7:0] load_current_ua, // Load source and sink current.
  output logic commut_ground,         // Commutation at ground ref.
  output logic serial_init,           // Pulse: controller initialised.
  output logic dac_default_load,      // Pulse: DAC input registers.
  output logic therm_alarm_en,        // Thermal alarm enabled.
  output logic [7:0] therm_limit_c,   // Thermal alarm threshold.
  output logic clamp_alarm_en,        // Clamp alarm enabled.
  output logic ovd_alarm_en,          // Overvoltage alarm enabled.
  output logic level_update_ok,       // Levels may move.
  output logic busy                   // Busy, active high copy.
);

  typedef enum logic [1:0] {
    ST_STATIC = 2'b00,
    ST_CLOCKED = 2'b01,
    ST_RUN = 2'b10
  } srb_dev_state_e;

  srb_dev_state_e state_ff, nxt_state;
  logic [1:0] rst_sync_ff;
  logic [2:0] sy1_ff, sy2_ff;
  logic sclk_q_ff, cs_q_ff;
  logic [9:0] rcnt_ff, nxt_rcnt;
  logic [9:0] bcnt_ff, nxt_bcnt;
  logic soft_pend_ff, nxt_soft_pend;
  srb_word_t shreg_ff;
  logic [4:0] bitcnt_ff;
  logic [6:0] degl_ff;
  logic instr_valid_ff, instr_read_ff;
  logic [6:0] addr_ff;
  logic [1:0] chan_ff;
  logic [15:0] data_ff;
  logic init_ff, therm_ff, busy_ff, hold_ff, upd_ok_ff;

  // ==========================================================================
  // Reset and pin synchronisers
  // The reset pin clears the sequencer with no clock at all; its release
  // is resynchronised only to gate the first edge out of the static state.
  wire arst_n = hresetn & lnk.rst_n;

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // Pins pass two flops; the third stage only feeds edge detection.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_ff <= 3'h3;
      sy2_ff <= 3'h3;
      sclk_q_ff <= 1'b1;
      cs_q_ff <= 1'b1;
    end else begin
      sy1_ff <= {lnk.sdi, lnk.cs_n, lnk.sclk};
      sy2_ff <= sy1_ff;
      sclk_q_ff <= sy2_ff[0];
      cs_q_ff <= sy2_ff[1];
    end
  end

  // ==========================================================================
  // Decoding of edges and the received word
  wire released = rst_sync_ff[1];
  wire sclk_rise = sy2_ff[0] & ~sclk_q_ff;
  wire cs_low = ~sy2_ff[1];
  wire cs_fall = ~sy2_ff[1] & cs_q_ff;
  wire cs_rise = sy2_ff[1] & ~cs_q_ff;
  wire in_run = state_ff == ST_RUN;
  wire word_ok = bitcnt_ff == WORD_BITS_C;
  wire instr_end = cs_rise & word_ok & in_run;
  wire is_write = ~shreg_ff[RW_BIT];
  wire [6:0] w_addr = shreg_ff[ADDR_HI:ADDR_LO];
  wire soft_hit = instr_end & is_write & (w_addr == ADDR_SOFT_RST) &
                  shreg_ff[SOFT_RST_BIT];
  wire dac_hit = instr_end & is_write & (w_addr != ADDR_NOP0) &
                 (w_addr <= ADDR_DAC_LAST);
  // Fixed length per instruction type.
  wire [9:0] need = srb_busy_need(shreg_ff);
  wire [9:0] left = (sclk_rise && bcnt_ff != 10'h000) ?
                    bcnt_ff - 10'h001 : bcnt_ff;

  // ==========================================================================
  // Reset sequencer
  // A soft reset is noted at select release, takes hold on the next edge
  // and starts counting on the edge after that.
  always_comb begin
    nxt_state = state_ff;
    nxt_rcnt = rcnt_ff;
    nxt_soft_pend = soft_pend_ff;
    nxt_bcnt = left;
    case (state_ff)
      ST_STATIC: begin
        nxt_bcnt = 10'h000;
        if (sclk_rise && released) begin
          nxt_state = ST_CLOCKED;
          nxt_rcnt = 10'h001;
        end
      end
      ST_CLOCKED: begin
        nxt_bcnt = 10'h000;
        if (sclk_rise) begin
          nxt_rcnt = rcnt_ff + 10'h001;
          if (rcnt_ff == RESET_CLKS - 10'h001)
            nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (soft_hit)
          nxt_soft_pend = 1'b1;
        else if (soft_pend_ff && sclk_rise) begin
          nxt_soft_pend = 1'b0;
          nxt_state = ST_STATIC;
        end
        // Keep the longer of the two, never shorten.
        if (instr_end && !soft_hit && need > left)
          nxt_bcnt = need;
      end
      default: begin
        nxt_state = ST_STATIC;
        nxt_soft_pend = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_STATIC;
      rcnt_ff <= 10'h000;
      soft_pend_ff <= 1'b0;
      bcnt_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      rcnt_ff <= nxt_rcnt;
      soft_pend_ff <= nxt_soft_pend;
      bcnt_ff <= nxt_bcnt;
    end
  end

  // ==========================================================================
  // Instruction shift register, sampled on rising serial-clock edges
  // Bits beyond the word length saturate the count and void the word.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      shreg_ff <= '0;
      bitcnt_ff <= 5'h00;
    end else if (cs_fall) begin
      bitcnt_ff <= 5'h00;
    end else if (sclk_rise && cs_low) begin
      shreg_ff <= {shreg_ff[WORD_BITS-2:0], sy2_ff[2]};
      if (bitcnt_ff != 5'h1F)
        bitcnt_ff <= bitcnt_ff + 5'h01;
    end
  end

  // A read fills address and channel only; data keeps its last write.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      instr_valid_ff <= 1'b0;
      instr_read_ff <= 1'b0;
      addr_ff <= 7'h00;
      chan_ff <= 2'h0;
      data_ff <= 16'h0000;
    end else begin
      instr_valid_ff <= instr_end;
      if (instr_end) begin
        instr_read_ff <= ~is_write;
        addr_ff <= w_addr;
        chan_ff <= shreg_ff[CH_HI:CH_LO];
        if (is_write)
          data_ff <= shreg_ff[DATA_HI:0];
      end
    end
  end

  // ==========================================================================
  // Static state, alarms, busy and deglitch
  // Static outputs come from one flop set by the async reset itself.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_ff <= 1'b1;
      busy_ff <= 1'b1;
      init_ff <= 1'b0;
      therm_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_state != ST_RUN;
      busy_ff <= nxt_state != ST_RUN || nxt_soft_pend ||
                 nxt_bcnt != 10'h000;
      init_ff <= state_ff == ST_STATIC && nxt_state == ST_CLOCKED;
      if (nxt_state == ST_STATIC)
        therm_ff <= 1'b0;
      else if (state_ff == ST_STATIC && nxt_state == ST_CLOCKED)
        therm_ff <= 1'b1;
    end
  end

  // Retriggers on reset completion and on each converter write; levels
  // stay put until the count runs out.
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      degl_ff <= 7'h00;
      upd_ok_ff <= 1'b0;
    end else begin
      if ((state_ff == ST_CLOCKED && nxt_state == ST_RUN) || dac_hit)
        degl_ff <= 7'(DEGLITCH_CYC);
      else if (degl_ff != 7'h00)
        degl_ff <= degl_ff - 7'h01;
      upd_ok_ff <= in_run && !hold_ff && degl_ff == 7'h00 &&
                   !dac_hit;
    end
  end

  // ==========================================================================
  // Output assignments
  // Busy drives the open-drain pin low while active.
  assign lnk.busy_o = 1'b0;
  assign lnk.busy_oe = busy_ff;
  assign busy = busy_ff;
  assign instr_valid = instr_valid_ff;
  assign instr_read = instr_read_ff;
  assign instr_addr = addr_ff;
  assign instr_chan = chan_ff;
  assign instr_data = data_ff;
  assign reset_hold = hold_ff;
  assign ctrl_default = hold_ff;
  assign cal_clear = hold_ff;
  assign level_to_ground = hold_ff;
  assign driver_off = hold_ff;
  assign pmu_off = hold_ff;
  assign load_force_on = hold_ff;
  assign load_current_ua = LOAD_CURRENT_UA;
  assign commut_ground = hold_ff;
  assign serial_init = init_ff;
  assign dac_default_load = init_ff;
  assign therm_alarm_en = therm_ff;
  assign therm_limit_c = THERM_LIMIT_C;
  // Both alarms are tied off; nothing here can enable them.
  assign clamp_alarm_en = 1'b0;
  assign ovd_alarm_en = 1'b0;
  assign level_update_ok = upd_ok_ff;

endmodule

// ### core/srb_host_end.sv
// Host end: AHB-Lite slave registers driving the serial link master.
// Assumes one AHB-Lite master; the serial clock is divided from hclk.
`timescale 1ns/1ps
module srb_host_end
  import srb_pkg::*;
(
  input wire logic hclk,          // System clock.
  input wire logic hresetn,       // Async reset, active low.
  input wire logic hsel,          // Slave select.
  input wire logic [31:0] haddr,  // Address.
  input wire logic [1:0] htrans,  // Transfer type.
  input wire logic hwrite,        // Write strobe.
  input wire logic [2:0] hsize,   // Transfer size, words only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready,        // Bus ready.
  output logic hreadyout,         // Always ready.
  output logic [31:0] hrdata,     // Read data.
  output logic hresp,             // Always OKAY.
  input wire logic power_good,    // Supplies stable, async pin.
  srb_link_if.host lnk            // Serial link to the device.
);

  typedef enum logic [2:0] {
    HS_PWR = 3'b000,
    HS_IDLE = 3'b001,
    HS_RSTLOW = 3'b010,
    HS_SHIFT = 3'b011,
    HS_TAIL = 3'b100
  } srb_host_state_e;

  srb_host_state_e state_ff, nxt_state;
  logic [2:0] div_ff;
  logic [1:0] pg_ff, busy_sy_ff;
  logic sclk_ff, nxt_sclk, cs_n_ff, nxt_cs_n, sdi_ff, nxt_sdi;
  srb_word_t sh_ff, nxt_sh, cmd_ff;
  logic [4:0] bits_ff, nxt_bits;
  logic [9:0] ecnt_ff, nxt_ecnt, need_ff, nxt_need;
  logic [3:0] hold_ff, nxt_hold;
  logic cmd_pend_ff, rst_pend_ff;
  logic ap_we_ff;
  logic [3:0] ap_addr_ff;
  logic [31:0] hrdata_ff;

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  wire take = hsel & htrans[1] & hready;
  wire idle = state_ff == HS_IDLE && !cmd_pend_ff && !rst_pend_ff;
  wire wr_cmd = ap_we_ff && ap_addr_ff == REG_CMD && idle;
  wire wr_rst = ap_we_ff && ap_addr_ff == REG_CTRL && hwdata[0] && idle;
  wire busy_act = ~busy_sy_ff[1];
  wire [31:0] status = {29'h0, idle, busy_act, !idle};
  wire [31:0] rd_mux = (haddr[3:0] == REG_CMD) ? {6'h00, cmd_ff} :
                       (haddr[3:0] == REG_STATUS) ? status : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_we_ff <= 1'b0;
      ap_addr_ff <= 4'h0;
      hrdata_ff <= 32'h0;
    end else begin
      ap_we_ff <= take & hwrite;
      ap_addr_ff <= haddr[3:0];
      if (take && !hwrite)
        hrdata_ff <= rd_mux;
    end
  end

  // Requests wait here for the next divider tick; busy engines ignore them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ff <= '0;
      cmd_pend_ff <= 1'b0;
      rst_pend_ff <= 1'b0;
    end else begin
      if (wr_cmd) begin
        cmd_ff <= hwdata[WORD_BITS-1:0];
        cmd_pend_ff <= 1'b1;
      end else if (state_ff == HS_SHIFT)
        cmd_pend_ff <= 1'b0;
      if (wr_rst)
        rst_pend_ff <= 1'b1;
      else if (state_ff == HS_RSTLOW)
        rst_pend_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial clock divider and pin synchronisers
  wire tick = div_ff == SCLK_HALF_CYC - 3'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 3'h0;
      pg_ff <= 2'h0;
      busy_sy_ff <= 2'h3;
    end else begin
      div_ff <= tick ? 3'h0 : div_ff + 3'h1;
      pg_ff <= {pg_ff[0], power_good};
      busy_sy_ff <= {busy_sy_ff[0], lnk.busy_n};
    end
  end

  // ==========================================================================
  // Link sequencer, advancing only on divider ticks
  wire rise = tick & ~sclk_ff;
  wire fall = tick & sclk_ff;
  // The clock stops only once the count is met and busy has gone.
  wire tail_done = ecnt_ff >= need_ff && ecnt_ff >= REARM_CLKS &&
                   !busy_act;

  always_comb begin
    nxt_state = state_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_n = cs_n_ff;
    nxt_sdi = sdi_ff;
    nxt_sh = sh_ff;
    nxt_bits = bits_ff;
    nxt_ecnt = ecnt_ff;
    nxt_need = need_ff;
    nxt_hold = hold_ff;
    case (state_ff)
      HS_PWR: begin
        if (pg_ff[1] && tick) begin
          nxt_state = HS_RSTLOW;
          nxt_hold = 4'h0;
        end
      end
      HS_IDLE: begin
        if (tick && rst_pend_ff) begin
          nxt_state = HS_RSTLOW;
          nxt_hold = 4'h0;
        end else if (tick && cmd_pend_ff) begin
          nxt_state = HS_SHIFT;
          nxt_cs_n = 1'b0;
          nxt_sdi = cmd_ff[WORD_BITS-1];
          nxt_sh = {cmd_ff[WORD_BITS-2:0], 1'b0};
          nxt_bits = 5'h00;
          // Soft reset holds one extra edge before its count.
          nxt_need = srb_busy_need(cmd_ff);
          if (nxt_need == RESET_CLKS)
            nxt_need = RESET_CLKS + 10'h001;
        end
      end
      HS_RSTLOW: begin
        if (tick) begin
          nxt_hold = hold_ff + 4'h1;
          if (hold_ff == RST_HOLD_TICKS) begin
            nxt_state = HS_TAIL;
            nxt_ecnt = 10'h000;
            nxt_need = RESET_CLKS;
          end
        end
      end
      HS_SHIFT: begin
        if (rise) begin
          nxt_sclk = 1'b1;
          nxt_bits = bits_ff + 5'h01;
        end else if (fall) begin
          nxt_sclk = 1'b0;
          if (bits_ff == WORD_BITS_C) begin
            nxt_cs_n = 1'b1;
            nxt_state = HS_TAIL;
            nxt_ecnt = 10'h000;
          end else begin
            nxt_sdi = sh_ff[WORD_BITS-1];
            nxt_sh = {sh_ff[WORD_BITS-2:0], 1'b0};
          end
        end
      end
      HS_TAIL: begin
        if (rise) begin
          nxt_sclk = 1'b1;
          if (ecnt_ff != 10'h3FF)
            nxt_ecnt = ecnt_ff + 10'h001;
        end else if (fall) begin
          nxt_sclk = 1'b0;
          if (tail_done)
            nxt_state = HS_IDLE;
        end
      end
      default: nxt_state = HS_PWR;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= HS_PWR;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sdi_ff <= 1'b0;
      sh_ff <= '0;
      bits_ff <= 5'h00;
      ecnt_ff <= 10'h000;
      need_ff <= 10'h000;
      hold_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
      sdi_ff <= nxt_sdi;
      sh_ff <= nxt_sh;
      bits_ff <= nxt_bits;
      ecnt_ff <= nxt_ecnt;
      need_ff <= nxt_need;
      hold_ff <= nxt_hold;
    end
  end

  // ==========================================================================
  // Outputs
  assign lnk.rst_n = !(state_ff == HS_PWR || state_ff == HS_RSTLOW);
  assign lnk.cs_n = cs_n_ff;
  assign lnk.sclk = sclk_ff;
  assign lnk.sdi = sdi_ff;
  assign hreadyout = 1'b1;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

endmodule

// ### tb/srb_link_properties.sv
// Checker for the serial link between the host and device ends.
// Assumes sclk and cs_n come from hclk flops in the host end.
`timescale 1ns/1ps
module srb_link_properties (
  input wire logic hclk,    // System clock.
  input wire logic hresetn, // Async reset, active low.
  input wire logic rst_n,   // Reset pin.
  input wire logic cs_n,    // Select.
  input wire logic sclk,    // Serial clock.
  input wire logic sdi,     // Serial data.
  input wire logic busy_o,  // Busy drive value.
  input wire logic busy_oe, // Busy pull-down.
  input wire logic busy_n   // Resolved busy wire.
);
  // ==========================================================================
  // Edges since the last select change, and the word shifted in.
  logic [9:0] cnt_ff;
  logic [9:0] need_ff;
  logic [9:0] nxt_need;
  logic [25:0] sh_ff;
  logic [6:0] adr;
  assign adr = sh_ff[24:18];
  // A soft reset adds its one static edge before the 744.
  assign nxt_need = (!sh_ff[25] && adr == 7'h7E && sh_ff[0]) ? 10'h2E9 :
    (sh_ff[25] || adr == 7'h00 || adr > 7'h0F) ? 10'h003 :
    (adr == 7'h01 || adr == 7'h03) ? 10'h015 : 10'h012;
  // The pin reset pins the count at zero so edges count from release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 10'h000;
      need_ff <= 10'h2E8;
      sh_ff <= 26'h0;
    end else if (!rst_n || $changed(cs_n)) begin
      cnt_ff <= 10'h000;
      need_ff <= !rst_n ? 10'h2E8 : (cs_n ? nxt_need : need_ff);
    end else if ($rose(sclk)) begin
      cnt_ff <= cnt_ff + 10'h001;
      sh_ff <= cs_n ? sh_ff : {sh_ff[24:0], sdi};
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence frame_end;
    $rose(cs_n) ##0 rst_n;
  endsequence
  // ==========================================================================
  // Link properties.
  a_reset_busy:
    assert property (!rst_n |-> busy_oe && !busy_n)
    else $error("busy not held in reset");
  a_instr_busy:
    assert property (frame_end |-> ##[1:8] busy_oe)
    else $error("no busy after instruction");
  a_busy_len:
    assert property ($fell(busy_oe) |-> cnt_ff == need_ff)
    else $error("busy length wrong");
  a_static_hold:
    assert property ($rose(rst_n) |-> busy_oe [*8])
    else $error("busy dropped in static reset");
  a_word_bits:
    assert property ($rose(cs_n) |-> cnt_ff == 10'h01A)
    else $error("frame not 26 bits");
  a_rearm_wait:
    assert property ($fell(cs_n) |-> busy_n && cnt_ff >= 10'h004)
    else $error("select too early");
  a_clock_busy:
    assert property (!busy_n && rst_n |-> ##[1:9] $changed(sclk))
    else $error("clock stopped while busy");
  a_stray_busy:
    assert property ($rose(busy_oe) |-> !rst_n || cnt_ff < 10'h008)
    else $error("busy without cause");
endmodule

// ### tb/serial_reset_and_busy_sequencer_test.sv
// Bench joining host and device ends over the serial link.
// Assumes the host end divides the serial clock from hclk.
`timescale 1ns/1ps
module serial_reset_and_busy_sequencer_test;
  import srb_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic power_good = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, d;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hready, iv, ird, hold, luok, therm;
  logic [6:0] iad;
  logic [1:0] ich;
  logic [7:0] lcur;
  logic [25:0] w;
  logic [9:0] exp_q[$];
  logic [9:0] wq[$];
  logic [6:0] adl[11] = '{7'h00, 7'h20, 7'h50, 7'h60, 7'h10, 7'h45,
    7'h05, 7'h0F, 7'h01, 7'h03, 7'h02};
  logic [31:0] seed = 32'd93263;
  int rises, compares, error_cnt;
  srb_link_if lnk();
  srb_host_end i_srb_host_end(.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(), .power_good(power_good), .lnk(lnk.host));
  srb_dev_end i_srb_dev_end(.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev),
    .instr_valid(iv), .instr_read(ird), .instr_addr(iad), .instr_chan(ich),
    .instr_data(), .reset_hold(hold), .ctrl_default(), .cal_clear(),
    .level_to_ground(), .driver_off(), .pmu_off(), .load_force_on(),
    .load_current_ua(lcur), .commut_ground(), .serial_init(),
    .dac_default_load(), .therm_alarm_en(therm), .therm_limit_c(),
    .clamp_alarm_en(), .ovd_alarm_en(), .level_update_ok(luok), .busy());
  srb_link_properties i_srb_link_properties(.hclk(hclk), .hresetn(hresetn),
    .rst_n(lnk.rst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .sdi(lnk.sdi),
    .busy_o(lnk.busy_o), .busy_oe(lnk.busy_oe), .busy_n(lnk.busy_n));
  // ==========================================================================
  // Clock, edge counting and shared tasks.
  initial forever #20 hclk = ~hclk;
  // Edges after a select release or a pin reset make up the busy span.
  always @(posedge lnk.sclk) if (lnk.cs_n && lnk.rst_n) rises++;
  always @(posedge lnk.cs_n or negedge lnk.rst_n) rises = 0;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] need(input logic [25:0] v);
    if (v[25] || v[24:18] == 7'h00 || v[24:18] > 7'h0F) return 10'h003;
    if (v[24:18] == 7'h01 || v[24:18] == 7'h03) return 10'h015;
    return 10'h012;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, x);
    compares++;
    if (e !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, x);
    end
  endtask
  // The slave never stretches a phase, but both still wait on hready.
  task automatic ahb(input logic wr, input logic [3:0] a, input [31:0] v);
    haddr <= {28'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_idle();
    r = 32'h0;
    while (r[2] !== 1'b1) ahb(1'b0, REG_STATUS, 32'h0);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Monitors take the oldest note as each result appears.
  initial begin
    wait (hresetn === 1'b1);
    forever begin
      wait (lnk.busy_n === 1'b0);
      wait (lnk.busy_n === 1'b1);
      chk("busy edges", exp_q.pop_front(), rises);
    end
  end
  always @(negedge hclk) begin
    if (iv === 1'b1 && wq.size() > 0)
      chk("instr", wq.pop_front(), {ird, iad, ich});
  end
  // ==========================================================================
  // Scenarios: power-up, every instruction kind, soft and hard reset.
  initial begin
    exp_q.push_back(10'h2E8);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    power_good <= 1'b1;
    wait_idle();
    $display("test power_up done");
    foreach (adl[i]) begin
      d = xs();
      w = {i == 10, adl[i], d[17:0]};
      exp_q.push_back(need(w));
      wq.push_back(w[25:16]);
      ahb(1'b1, REG_CMD, {6'h0, w});
      wait_idle();
    end
    $display("test instructions done");
    exp_q.push_back(10'h2E9);
    ahb(1'b1, REG_CMD, {7'h0, ADDR_SOFT_RST, 18'h00001});
    wait (lnk.busy_n === 1'b0);
    repeat (6) @(posedge hclk);
    chk("hold", 1'b1, hold);
    chk("load", 8'h64, lcur);
    chk("levels", 1'b0, luok);
    wait_idle();
    chk("therm", 1'b1, therm);
    repeat (DEGLITCH_CYC + 8) @(posedge hclk);
    chk("levels", 1'b1, luok);
    $display("test soft_reset done");
    exp_q.push_back(10'h2E8);
    ahb(1'b1, REG_CTRL, 32'h1);
    wait (lnk.rst_n === 1'b0);
    @(posedge hclk);
    chk("pin hold", 1'b1, hold);
    wait_idle();
    ahb(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, r);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h4, r);
    $display("test hard_reset done");
    test_done();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    test_done();
  end
endmodule
